// >>> inc/dbt_pkg.sv
// shared constants and types of the debug trigger csr unit
package dbt_pkg;
   // -------------------------------------------------------------------
   // csr addresses
   // -------------------------------------------------------------------
   localparam logic [11:0] CSR_TRIG_SELECT = 12'h7A0;
   localparam logic [11:0] CSR_TRIG_FIRST  = 12'h7A1;
   localparam logic [11:0] CSR_TRIG_SECOND = 12'h7A2;
   localparam logic [11:0] CSR_TRIG_THIRD  = 12'h7A3;
   localparam logic [11:0] CSR_DCSR        = 12'h7B0;
   localparam logic [11:0] CSR_DPC         = 12'h7B1;
   localparam logic [11:0] CSR_DSCRATCH    = 12'h7B2;

   // -------------------------------------------------------------------
   // match control layout
   // -------------------------------------------------------------------
   localparam int          POS_TYPE     = 28;
   localparam int          POS_DMODE    = 27;
   localparam int          POS_MASKMAX  = 21;
   localparam int          POS_SELECT   = 19;
   localparam int          POS_TIMING   = 18;
   localparam int          POS_ACTION   = 12;
   localparam int          POS_CHAIN    = 11;
   localparam int          POS_MATCH    = 7;
   localparam int          POS_M        = 6;
   localparam int          POS_S        = 4;
   localparam int          POS_U        = 3;
   localparam int          POS_X        = 2;
   localparam int          POS_W        = 1;
   localparam int          POS_R        = 0;

   localparam logic [3:0]  TYPE_NONE    = 4'h0;
   localparam logic [3:0]  TYPE_ADDR    = 4'h2;
   localparam logic [5:0]  MASKMAX_VAL  = 6'h04;
   localparam logic [5:0]  ACT_BREAK    = 6'h00;
   localparam logic [5:0]  ACT_DEBUG    = 6'h01;
   localparam logic [3:0]  MATCH_EXACT  = 4'h0;
   localparam logic [3:0]  MATCH_NAPOT  = 4'h1;
   localparam logic [3:0]  MATCH_GE     = 4'h2;
   localparam logic [3:0]  MATCH_LT     = 4'h3;
   localparam logic [1:0]  PRIV_U       = 2'h0;
   localparam logic [1:0]  PRIV_S       = 2'h1;
   localparam logic [1:0]  PRIV_M       = 2'h3;

   // reset values
   localparam logic [31:0] DCSR_RST     = 32'h0000_0000;
   localparam logic [31:0] DPC_RST      = 32'h0000_0000;
   localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
   localparam logic [31:0] TSEL_RST     = 32'h0000_0000;

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       dmode;
      logic [5:0] action;
      logic       chain;
      logic [3:0] match;
      logic       m;
      logic       s;
      logic       u;
      logic       x;
      logic       w;
      logic       r;
   } dbt_ctrl_t;

   localparam dbt_ctrl_t CTRL_RST = '0;

   typedef struct packed {
      logic        valid;
      logic        load;
      logic        store;
      logic        fetch;
      logic [1:0]  priv;
      logic [31:0] addr;
   } dbt_access_t;

   typedef struct packed {
      logic        valid;
      logic        we;
      logic [11:0] addr;
      logic [31:0] wdata;
   } dbt_csr_req_t;
endpackage

// >>> rtl/dbt_match.sv
// address comparator of one breakpoint trigger
module dbt_match
(
   // trigger setup
   input  dbt_pkg::dbt_ctrl_t   ctrl,
   input  logic [31:0]          maddr,
   // access under test
   input  dbt_pkg::dbt_access_t acc,
   // result
   output logic                 hit
);
   logic [31:0] care;
   logic        kind_ok;
   logic        priv_ok;
   logic        addr_ok;

   always_comb
   begin
      // napot: trailing ones of the address and the zero above them are masked
      care    = ~(maddr ^ (maddr + 32'h0000_0001));
      // [RULE18] kind and privilege
      kind_ok = (ctrl.r & acc.load) | (ctrl.w & acc.store) | (ctrl.x & acc.fetch);
      priv_ok = (ctrl.u & (acc.priv == dbt_pkg::PRIV_U)) |
                (ctrl.s & (acc.priv == dbt_pkg::PRIV_S)) |
                (ctrl.m & (acc.priv == dbt_pkg::PRIV_M));
      // [RULE12] match type decode
      unique case (ctrl.match)
         dbt_pkg::MATCH_NAPOT: addr_ok = (acc.addr & care) == (maddr & care);
         dbt_pkg::MATCH_GE:    addr_ok = acc.addr >= maddr;
         dbt_pkg::MATCH_LT:    addr_ok = acc.addr < maddr;
         default:              addr_ok = acc.addr == maddr;
      endcase
      hit = acc.valid & kind_ok & priv_ok & addr_ok;
   end
endmodule

// >>> rtl/dbt_csr_unit.sv
// debug and trigger csr unit of one hart
//
// Behaviour
// [RULE1] dcsr, dpc, dscratch debug mode only; select and trigger data also machine.
// [RULE2] a 32-bit select index picks the trigger bank behind the data addresses.
// [RULE3] select writes naming no trigger are dropped; index stays legal.
// [RULE4] software checks the type code to learn whether a trigger exists.
// [RULE5] top nibble of first data reads type: 0 none, 2 address match.
// [RULE6] machine access to trigger data with debug-only flag set is illegal.
// [RULE7] debug entry saves the pc; leaving debug resumes at the saved pc.
// [RULE8] four breakpoint triggers, usable from debug or machine mode.
// [RULE9] first data is match control, second match address, third reserved.
// [RULE10] control bits 0..2 qualify loads, stores and fetches.
// [RULE11] control bits 3, 4, 6 qualify user, supervisor, machine; bit 5 reserved.
// [RULE12] control bits 10..7 hold the warl match type.
// [RULE13] action field 17..12 resets 0, holds 0 or 1; chain bit 11 resets 0.
// [RULE14] timing and select bits read 0; only address before access.
// [RULE15] action 0 raises breakpoint exception, action 1 enters debug mode.
// [RULE16] chained trigger fires only if it and the next both match.
// [RULE17] unsupported warl writes leave a legal value in the field.
// [RULE18] a match counts only when access kind and privilege are enabled.
module dbt_csr_unit
#(
   parameter int NUM_TRIG = 4
)
(
   // clock and reset
   input  logic                 clk,
   input  logic                 rst,
   // hart state
   input  logic                 debug_mode,
   input  logic                 debug_enter,
   input  logic [31:0]          debug_enter_pc,
   // csr port
   input  dbt_pkg::dbt_csr_req_t csr_req,
   output logic                 csr_rsp_valid_q,
   output logic                 csr_rsp_illegal_q,
   output logic [31:0]          csr_rsp_rdata_q,
   // access checked against triggers
   input  dbt_pkg::dbt_access_t acc,
   output logic                 brk_exception_q,
   output logic                 brk_debug_q,
   output logic [31:0]          resume_pc_q
);
   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   // [RULE17] legalise a control write
   function automatic dbt_pkg::dbt_ctrl_t legal_ctrl(input logic [31:0] wd,
                                                     input logic        dbg,
                                                     input logic        last,
                                                     input dbt_pkg::dbt_ctrl_t old);
      dbt_pkg::dbt_ctrl_t c;
      c        = dbt_pkg::CTRL_RST;
      // [RULE10] load store fetch qualifiers
      c.r      = wd[dbt_pkg::POS_R];
      c.w      = wd[dbt_pkg::POS_W];
      c.x      = wd[dbt_pkg::POS_X];
      // [RULE11] privilege qualifiers
      c.u      = wd[dbt_pkg::POS_U];
      c.s      = wd[dbt_pkg::POS_S];
      c.m      = wd[dbt_pkg::POS_M];
      // [RULE12] unsupported match types fall back to exact
      c.match  = (wd[dbt_pkg::POS_MATCH +: 4] <= dbt_pkg::MATCH_LT) ?
                 wd[dbt_pkg::POS_MATCH +: 4] : dbt_pkg::MATCH_EXACT;
      // the last trigger has no neighbour, so its chain bit is tied low
      c.chain  = wd[dbt_pkg::POS_CHAIN] & ~last;
      // [RULE13] action only 0 or 1
      c.action = (wd[dbt_pkg::POS_ACTION +: 6] == dbt_pkg::ACT_DEBUG) ?
                 dbt_pkg::ACT_DEBUG : dbt_pkg::ACT_BREAK;
      // machine mode cannot claim a trigger for the debugger
      c.dmode  = dbg ? wd[dbt_pkg::POS_DMODE] : old.dmode;
      return c;
   endfunction

   function automatic logic [31:0] pack_ctrl(input dbt_pkg::dbt_ctrl_t c);
      logic [31:0] v;
      v = 32'h0000_0000;
      // [RULE5] type code
      v[dbt_pkg::POS_TYPE +: 4]    = dbt_pkg::TYPE_ADDR;
      v[dbt_pkg::POS_DMODE]        = c.dmode;
      v[dbt_pkg::POS_MASKMAX +: 6] = dbt_pkg::MASKMAX_VAL;
      // [RULE14] timing and select stay zero
      v[dbt_pkg::POS_SELECT]       = 1'b0;
      v[dbt_pkg::POS_TIMING]       = 1'b0;
      v[dbt_pkg::POS_ACTION +: 6]  = c.action;
      v[dbt_pkg::POS_CHAIN]        = c.chain;
      v[dbt_pkg::POS_MATCH +: 4]   = c.match;
      v[dbt_pkg::POS_M]            = c.m;
      v[dbt_pkg::POS_S]            = c.s;
      v[dbt_pkg::POS_U]            = c.u;
      v[dbt_pkg::POS_X]            = c.x;
      v[dbt_pkg::POS_W]            = c.w;
      v[dbt_pkg::POS_R]            = c.r;
      return v;
   endfunction

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   localparam int SW = $clog2(NUM_TRIG);

   dbt_pkg::dbt_ctrl_t ctrl_q [NUM_TRIG];
   dbt_pkg::dbt_ctrl_t ctrl_d [NUM_TRIG];
   logic [31:0]        maddr_q [NUM_TRIG];
   logic [31:0]        maddr_d [NUM_TRIG];
   logic [31:0]        tsel_q;
   logic [31:0]        tsel_d;
   logic [31:0]        dcsr_q;
   logic [31:0]        dcsr_d;
   logic [31:0]        dscratch_q;
   logic [31:0]        dscratch_d;
   logic [31:0]        dpc_d;
   logic               rsp_valid_d;
   logic               rsp_illegal_d;
   logic [31:0]        rsp_rdata_d;
   logic               brk_exc_d;
   logic               brk_dbg_d;
   logic [NUM_TRIG-1:0] hit;
   logic [NUM_TRIG-1:0] fire;
   logic [SW-1:0]      sel;
   logic               is_data;
   logic               illegal;
   logic               do_write;

   // -------------------------------------------------------------------
   // comparators
   // -------------------------------------------------------------------
   // [RULE8] one comparator per trigger
   for (genvar g = 0; g < NUM_TRIG; g++)
   begin : g_trig
      dbt_match u_match
      (
         .ctrl  (ctrl_q[g]),
         .maddr (maddr_q[g]),
         .acc   (acc),
         .hit   (hit[g])
      );
   end

   // -------------------------------------------------------------------
   // csr access and trigger action
   // -------------------------------------------------------------------
   always_comb
   begin
      ctrl_d        = ctrl_q;
      maddr_d       = maddr_q;
      tsel_d        = tsel_q;
      dcsr_d        = dcsr_q;
      dscratch_d    = dscratch_q;
      dpc_d         = resume_pc_q;
      rsp_rdata_d   = 32'h0000_0000;
      // [RULE2] select index picks bank
      sel           = tsel_q[SW-1:0];
      is_data       = (csr_req.addr == dbt_pkg::CSR_TRIG_FIRST) |
                      (csr_req.addr == dbt_pkg::CSR_TRIG_SECOND) |
                      (csr_req.addr == dbt_pkg::CSR_TRIG_THIRD);
      // [RULE1] debug-only registers
      illegal       = ~debug_mode & ((csr_req.addr == dbt_pkg::CSR_DCSR) |
                                     (csr_req.addr == dbt_pkg::CSR_DPC) |
                                     (csr_req.addr == dbt_pkg::CSR_DSCRATCH));
      // [RULE6] debug-owned trigger hidden from machine mode
      illegal       = illegal | (~debug_mode & is_data & ctrl_q[sel].dmode);
      do_write      = csr_req.valid & csr_req.we & ~illegal;
      rsp_valid_d   = csr_req.valid;
      rsp_illegal_d = csr_req.valid & illegal;

      // [RULE9] bank view through the three data addresses
      unique case (csr_req.addr)
         dbt_pkg::CSR_TRIG_SELECT: rsp_rdata_d = tsel_q;
         dbt_pkg::CSR_TRIG_FIRST:  rsp_rdata_d = pack_ctrl(ctrl_q[sel]);
         dbt_pkg::CSR_TRIG_SECOND: rsp_rdata_d = maddr_q[sel];
         dbt_pkg::CSR_DCSR:        rsp_rdata_d = dcsr_q;
         dbt_pkg::CSR_DPC:         rsp_rdata_d = resume_pc_q;
         dbt_pkg::CSR_DSCRATCH:    rsp_rdata_d = dscratch_q;
         default:                  rsp_rdata_d = 32'h0000_0000;
      endcase
      if (illegal)
      begin
         rsp_rdata_d = 32'h0000_0000;
      end

      if (do_write)
      begin
         unique case (csr_req.addr)
            // [RULE3] out-of-range index is not retained
            dbt_pkg::CSR_TRIG_SELECT:
            begin
               if (csr_req.wdata < 32'(NUM_TRIG))
               begin
                  tsel_d = csr_req.wdata;
               end
            end
            dbt_pkg::CSR_TRIG_FIRST:
               ctrl_d[sel] = legal_ctrl(csr_req.wdata, debug_mode,
                                        32'(sel) == 32'(NUM_TRIG - 1), ctrl_q[sel]);
            dbt_pkg::CSR_TRIG_SECOND: maddr_d[sel] = csr_req.wdata;
            dbt_pkg::CSR_DCSR:        dcsr_d       = csr_req.wdata;
            dbt_pkg::CSR_DPC:         dpc_d        = csr_req.wdata;
            dbt_pkg::CSR_DSCRATCH:    dscratch_d   = csr_req.wdata;
            default:                  dcsr_d       = dcsr_q;
         endcase
      end

      // [RULE7] save pc on debug entry; entry wins over a csr write
      if (debug_enter)
      begin
         dpc_d = debug_enter_pc;
      end

      // [RULE16] chain gating between neighbours
      for (int i = 0; i < NUM_TRIG; i++)
      begin
         fire[i] = hit[i] & ~ctrl_q[i].chain & ~debug_mode;
         if (i > 0)
         begin
            fire[i] = fire[i] & (~ctrl_q[i-1].chain | hit[i-1]);
         end
      end
      // [RULE15] action select, debug entry takes precedence
      brk_dbg_d = 1'b0;
      brk_exc_d = 1'b0;
      for (int i = 0; i < NUM_TRIG; i++)
      begin
         if (fire[i] & (ctrl_q[i].action == dbt_pkg::ACT_DEBUG))
         begin
            brk_dbg_d = 1'b1;
         end
         if (fire[i] & (ctrl_q[i].action == dbt_pkg::ACT_BREAK))
         begin
            brk_exc_d = 1'b1;
         end
      end
      brk_exc_d = brk_exc_d & ~brk_dbg_d;
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // [RULE13] control resets clear action and chain
         for (int i = 0; i < NUM_TRIG; i++)
         begin
            ctrl_q[i]  <= dbt_pkg::CTRL_RST;
            maddr_q[i] <= dbt_pkg::ADDR_RST;
         end
         tsel_q            <= dbt_pkg::TSEL_RST;
         dcsr_q            <= dbt_pkg::DCSR_RST;
         dscratch_q        <= dbt_pkg::DCSR_RST;
         resume_pc_q       <= dbt_pkg::DPC_RST;
         csr_rsp_valid_q   <= 1'b0;
         csr_rsp_illegal_q <= 1'b0;
         csr_rsp_rdata_q   <= 32'h0000_0000;
         brk_exception_q   <= 1'b0;
         brk_debug_q       <= 1'b0;
      end
      else
      begin
         ctrl_q            <= ctrl_d;
         maddr_q           <= maddr_d;
         tsel_q            <= tsel_d;
         dcsr_q            <= dcsr_d;
         dscratch_q        <= dscratch_d;
         resume_pc_q       <= dpc_d;
         csr_rsp_valid_q   <= rsp_valid_d;
         csr_rsp_illegal_q <= rsp_illegal_d;
         csr_rsp_rdata_q   <= rsp_rdata_d;
         brk_exception_q   <= brk_exc_d;
         brk_debug_q       <= brk_dbg_d;
      end
   end
endmodule

// >>> tb/dbt_csr_unit_chk.sv
// concurrent checks on the ports of the debug trigger csr unit
module dbt_csr_unit_chk
#(
   parameter int NUM_TRIG = 4
)
(
   // clock and reset
   input logic                  clk,
   input logic                  rst,
   // hart state
   input logic                  debug_mode,
   input logic                  debug_enter,
   input logic [31:0]           debug_enter_pc,
   // csr port
   input dbt_pkg::dbt_csr_req_t csr_req,
   input logic                  csr_rsp_valid_q,
   input logic                  csr_rsp_illegal_q,
   input logic [31:0]           csr_rsp_rdata_q,
   // trigger side
   input dbt_pkg::dbt_access_t  acc,
   input logic                  brk_exception_q,
   input logic                  brk_debug_q,
   input logic [31:0]           resume_pc_q
);
   timeunit 1ns;
   timeprecision 1ps;

   logic rd_sel;
   logic rd_t1;
   logic dbg_reg;
   assign rd_sel  = csr_req.valid && !csr_req.we && csr_req.addr == dbt_pkg::CSR_TRIG_SELECT;
   assign rd_t1   = csr_req.valid && !csr_req.we && csr_req.addr == dbt_pkg::CSR_TRIG_FIRST;
   assign dbg_reg = csr_req.addr inside {dbt_pkg::CSR_DCSR, dbt_pkg::CSR_DPC,
                                         dbt_pkg::CSR_DSCRATCH};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // -------------------------------------------------------------------
   // csr access
   // -------------------------------------------------------------------
   chk_rsp_follows_req: assert property (csr_req.valid |=> csr_rsp_valid_q)
      else $error("csr request got no response");
   chk_debug_only_regs: assert property (csr_req.valid && !debug_mode && dbg_reg
      |=> csr_rsp_illegal_q && csr_rsp_rdata_q == 32'h0) else $error("debug register open");
   chk_select_open_m: assert property (csr_req.valid && !debug_mode
      && csr_req.addr == dbt_pkg::CSR_TRIG_SELECT |=> !csr_rsp_illegal_q)
      else $error("select refused in machine mode");
   chk_select_legal: assert property (rd_sel |=> csr_rsp_rdata_q < NUM_TRIG)
      else $error("select reads unimplemented index");
   chk_type_code: assert property (rd_t1
      |=> csr_rsp_illegal_q || csr_rsp_rdata_q[31:28] == dbt_pkg::TYPE_ADDR)
      else $error("type code wrong");
   chk_fixed_zero_bits: assert property (rd_t1
      |=> csr_rsp_rdata_q[19:18] == 2'h0 && !csr_rsp_rdata_q[5]) else $error("fixed bits set");
   chk_warl_legal: assert property (rd_t1
      |=> csr_rsp_rdata_q[17:12] <= 6'h01 && csr_rsp_rdata_q[10:7] <= 4'h3)
      else $error("illegal field value read back");

   // -------------------------------------------------------------------
   // debug pc and breakpoints
   // -------------------------------------------------------------------
   chk_pc_saved: assert property (debug_enter
      |=> resume_pc_q == $past(debug_enter_pc)) else $error("pc not saved on debug entry");
   chk_no_access_quiet: assert property (!acc.valid || debug_mode
      |=> !brk_exception_q && !brk_debug_q) else $error("breakpoint without access");
   chk_single_action: assert property (!(brk_exception_q && brk_debug_q))
      else $error("both breakpoint actions at once");
endmodule

bind dbt_csr_unit dbt_csr_unit_chk #(.NUM_TRIG(NUM_TRIG)) u_chk
(
   .clk               (clk),
   .rst               (rst),
   .debug_mode        (debug_mode),
   .debug_enter       (debug_enter),
   .debug_enter_pc    (debug_enter_pc),
   .csr_req           (csr_req),
   .csr_rsp_valid_q   (csr_rsp_valid_q),
   .csr_rsp_illegal_q (csr_rsp_illegal_q),
   .csr_rsp_rdata_q   (csr_rsp_rdata_q),
   .acc               (acc),
   .brk_exception_q   (brk_exception_q),
   .brk_debug_q       (brk_debug_q),
   .resume_pc_q       (resume_pc_q)
);

// >>> tb/dbt_hart_model.sv
// hart model: debug entry on halt or breakpoint, resume at the saved pc
module dbt_hart_model
(
   // clock and reset
   input  logic        clk,
   input  logic        rst,
   // bench commands
   input  logic        halt_req,
   input  logic        resume_req,
   input  logic [31:0] cur_pc,
   // csr unit side
   input  logic        brk_debug_q,
   input  logic [31:0] resume_pc_q,
   output logic        debug_mode,
   output logic        debug_enter,
   output logic [31:0] debug_enter_pc,
   output logic [31:0] fetch_pc
);
   timeunit 1ns;
   timeprecision 1ps;

   assign debug_enter    = !debug_mode && (halt_req || brk_debug_q);
   assign debug_enter_pc = cur_pc;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         debug_mode <= 1'b0;
         fetch_pc   <= 32'h0000_0000;
      end
      else if (debug_enter)
         debug_mode <= 1'b1;
      else if (debug_mode && resume_req)
      begin
         debug_mode <= 1'b0;
         fetch_pc   <= resume_pc_q;
      end
   end
endmodule

// >>> tb/dbt_csr_unit_tb.sv
// self-checking bench of the debug trigger csr unit
module dbt_csr_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int         NT = 4;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  halt_req = 1'b0;
   logic                  resume_req = 1'b0;
   logic [31:0]           cur_pc = 32'h0000_0000;
   dbt_pkg::dbt_csr_req_t req = '0;
   dbt_pkg::dbt_access_t  acc = '0;
   logic                  debug_mode, debug_enter, brk_exc, brk_dbg, rsp_v, rsp_ill;
   logic [31:0]           enter_pc, resume_pc, fetch_pc, rsp_rd;
   logic [1:0]            pv_t [3] = '{dbt_pkg::PRIV_U, dbt_pkg::PRIV_S, dbt_pkg::PRIV_M};
   int                    pb_t [3] = '{3, 4, 6};
   int                    miscompares = 0;
   int                    compares = 0;

   always #10 clk = ~clk;

   dbt_csr_unit #(.NUM_TRIG(NT)) dut
   (
      .clk (clk), .rst (rst), .debug_mode (debug_mode), .debug_enter (debug_enter),
      .debug_enter_pc (enter_pc), .csr_req (req), .csr_rsp_valid_q (rsp_v),
      .csr_rsp_illegal_q (rsp_ill), .csr_rsp_rdata_q (rsp_rd), .acc (acc),
      .brk_exception_q (brk_exc), .brk_debug_q (brk_dbg), .resume_pc_q (resume_pc)
   );

   dbt_hart_model hart
   (
      .clk (clk), .rst (rst), .halt_req (halt_req), .resume_req (resume_req),
      .cur_pc (cur_pc), .brk_debug_q (brk_dbg), .resume_pc_q (resume_pc),
      .debug_mode (debug_mode), .debug_enter (debug_enter), .debug_enter_pc (enter_pc),
      .fetch_pc (fetch_pc)
   );

   // -------------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic csr(input logic we, input logic [11:0] a, input logic [31:0] wd,
                      input logic [31:0] exp, input logic ill);
      req = '{valid: 1'b1, we: we, addr: a, wdata: wd};
      @(negedge clk);
      req.valid = 1'b0;
      chk({30'h0, rsp_v, rsp_ill}, {30'h0, 1'b1, ill});
      if (!we)
         chk(rsp_rd, exp);
      // an idle edge keeps the next call from raising valid in this same step
      @(negedge clk);
   endtask

   task automatic setup(input int i, input logic [31:0] ctl, input logic [31:0] ad);
      csr(1'b1, dbt_pkg::CSR_TRIG_SELECT, 32'(i), 32'h0, 1'b0);
      csr(1'b1, dbt_pkg::CSR_TRIG_FIRST, ctl, 32'h0, 1'b0);
      csr(1'b1, dbt_pkg::CSR_TRIG_SECOND, ad, 32'h0, 1'b0);
   endtask

   task automatic probe(input logic [2:0] kind, input logic [1:0] pv, input logic [31:0] ad,
                        input logic ex, input logic db);
      acc = '{valid: 1'b1, load: kind[0], store: kind[1], fetch: kind[2], priv: pv, addr: ad};
      @(negedge clk);
      acc.valid = 1'b0;
      chk({30'h0, brk_exc, brk_dbg}, {30'h0, ex, db});
      @(negedge clk);
   endtask

   task automatic halt(input logic [31:0] pc);
      halt_req = 1'b1;
      cur_pc   = pc;
      @(negedge clk);
      halt_req = 1'b0;
      chk(resume_pc, pc);
   endtask

   task automatic resume(input logic [31:0] pc);
      resume_req = 1'b1;
      @(negedge clk);
      resume_req = 1'b0;
      chk({fetch_pc[30:0], debug_mode}, {pc[30:0], 1'b0});
   endtask

   task automatic end_sim();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // -------------------------------------------------------------------
   // tests
   // -------------------------------------------------------------------
   initial
   begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      csr(1'b0, dbt_pkg::CSR_TRIG_SELECT, 32'h0, 32'h0, 1'b0);
      csr(1'b0, dbt_pkg::CSR_TRIG_FIRST, 32'h0, 32'h2080_0000, 1'b0);
      for (int a = 0; a < 3; a++)
         csr(1'b0, 12'(dbt_pkg::CSR_DCSR + a), 32'h0, 32'h0, 1'b1);
      for (int i = 0; i < NT; i++)
         setup(i, 32'h0, 32'hA000_0000 | 32'(i));
      for (int i = 0; i < NT; i++)
      begin
         csr(1'b1, dbt_pkg::CSR_TRIG_SELECT, 32'(i), 32'h0, 1'b0);
         csr(1'b0, dbt_pkg::CSR_TRIG_FIRST, 32'h0, 32'h2080_0000, 1'b0);
         csr(1'b0, dbt_pkg::CSR_TRIG_SECOND, 32'h0, 32'hA000_0000 | 32'(i), 1'b0);
         csr(1'b0, dbt_pkg::CSR_TRIG_THIRD, 32'h0, 32'h0, 1'b0);
      end
      csr(1'b1, dbt_pkg::CSR_TRIG_SELECT, 32'(NT), 32'h0, 1'b0);
      csr(1'b1, dbt_pkg::CSR_TRIG_SELECT, 32'hFFFF_FFFF, 32'h0, 1'b0);
      csr(1'b0, dbt_pkg::CSR_TRIG_SELECT, 32'h0, 32'h3, 1'b0);
      csr(1'b1, dbt_pkg::CSR_TRIG_FIRST, 32'hFFFF_FFFF, 32'h0, 1'b0);
      csr(1'b0, dbt_pkg::CSR_TRIG_FIRST, 32'h0, 32'h2080_005F, 1'b0);
      for (int m = 0; m < 4; m++)
      begin
         csr(1'b1, dbt_pkg::CSR_TRIG_FIRST, 32'h1000 | 32'(m << 7), 32'h0, 1'b0);
         csr(1'b0, dbt_pkg::CSR_TRIG_FIRST, 32'h0, 32'h2080_1000 | 32'(m << 7), 1'b0);
      end
      halt(32'h1234_5678);
      csr(1'b0, dbt_pkg::CSR_DPC, 32'h0, 32'h1234_5678, 1'b0);
      csr(1'b1, dbt_pkg::CSR_DSCRATCH, 32'h5A5A_0F0F, 32'h0, 1'b0);
      csr(1'b0, dbt_pkg::CSR_DSCRATCH, 32'h0, 32'h5A5A_0F0F, 1'b0);
      csr(1'b1, dbt_pkg::CSR_DCSR, 32'hC3C3_0101, 32'h0, 1'b0);
      csr(1'b0, dbt_pkg::CSR_DCSR, 32'h0, 32'hC3C3_0101, 1'b0);
      csr(1'b1, dbt_pkg::CSR_TRIG_SELECT, 32'h0, 32'h0, 1'b0);
      csr(1'b1, dbt_pkg::CSR_TRIG_FIRST, 32'hFFFF_FFFF, 32'h0, 1'b0);
      csr(1'b0, dbt_pkg::CSR_TRIG_FIRST, 32'h0, 32'h2880_085F, 1'b0);
      csr(1'b1, dbt_pkg::CSR_DPC, 32'h0000_0400, 32'h0, 1'b0);
      resume(32'h0000_0400);
      csr(1'b0, dbt_pkg::CSR_TRIG_FIRST, 32'h0, 32'h0, 1'b1);
      csr(1'b1, dbt_pkg::CSR_TRIG_SECOND, 32'h0, 32'h0, 1'b1);
      halt(32'h0000_0500);
      csr(1'b1, dbt_pkg::CSR_TRIG_FIRST, 32'h0, 32'h0, 1'b0);
      resume(32'h0000_0500);
      setup(0, 32'h0000_0044, 32'h0000_0100);
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0100, 1'b1, 1'b0);
      probe(3'b001, dbt_pkg::PRIV_M, 32'h0000_0100, 1'b0, 1'b0);
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0104, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
         setup(0, 32'h0000_0058 | 32'(1 << k), 32'h0000_0100);
         probe(3'(1 << k), dbt_pkg::PRIV_U, 32'h0000_0100, 1'b1, 1'b0);
         setup(0, 32'h0000_0004 | 32'(1 << pb_t[k]), 32'h0000_0100);
         probe(3'b100, pv_t[k], 32'h0000_0100, 1'b1, 1'b0);
         probe(3'b100, pv_t[(k + 1) % 3], 32'h0000_0100, 1'b0, 1'b0);
      end
      setup(0, 32'h0000_00C4, 32'h0000_0203);
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0207, 1'b1, 1'b0);
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0208, 1'b0, 1'b0);
      setup(0, 32'h0000_1044, 32'h0000_0100);
      cur_pc = 32'h0000_0100;
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0100, 1'b0, 1'b1);
      @(negedge clk);
      chk({31'h0, debug_mode}, 32'h1);
      resume(32'h0000_0100);
      setup(0, 32'h0000_0944, 32'h0000_0200);
      setup(1, 32'h0000_01C4, 32'h0000_0300);
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0250, 1'b1, 1'b0);
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0350, 1'b0, 1'b0);
      probe(3'b100, dbt_pkg::PRIV_M, 32'h0000_0150, 1'b0, 1'b0);
      end_sim();
   end

   initial
   begin
      #400000;
      miscompares++;
      end_sim();
   end
endmodule
